// ===== design/ulis_pkg.sv
// Purpose: constants, register map and types of the serial port block
// Assumes: 32-bit AHB-Lite register access, one clock (hclk, 200 MHz)
// Notes: offsets are byte addresses of aligned words
// Notes on behaviour
// (RL1) LIN break lasts thirteen plus field bit times
// (RL2) timeout raw flag sets whatever the mask
// (RL3) smart-card mode: transmit line carries bit clock
// (RL4) no parity interrupt without a raw flag
// (RL5) infrared mode: receive line held high outside
// (RL6) LIN/infrared: single DMA requests keep transfers moving
// (RL7) level-flag transfers need fast clock; prefer DMA
// (RL8) masked equals raw and mask; irq ors them
package ulis_pkg;
  localparam logic [7:0] OFF_DATA   = 8'h00;
  localparam logic [7:0] OFF_CTRL   = 8'h04;
  localparam logic [7:0] OFF_LINCTL = 8'h08;
  localparam logic [7:0] OFF_BAUD   = 8'h0C;
  localparam logic [7:0] OFF_RIS    = 8'h10;
  localparam logic [7:0] OFF_IM     = 8'h14;
  localparam logic [7:0] OFF_MIS    = 8'h18;
  localparam logic [7:0] OFF_STAT   = 8'h1C;

  localparam int CTRL_EN     = 0;
  localparam int CTRL_MODE   = 1;
  localparam int CTRL_PAR_EN = 3;
  localparam int CTRL_DMA_RX = 4;
  localparam int CTRL_DMA_TX = 5;
  localparam int CTRL_W      = 6;
  localparam int LIN_BRK_GO  = 0;
  localparam int LIN_BREAK_LENGTH_FIELD    = 4;
  localparam int LIN_W       = 6;

  localparam int INT_RX  = 0;
  localparam int INT_TX  = 1;
  localparam int INT_RT  = 2;
  localparam int INT_PE  = 3;
  localparam int INT_BRK = 4;
  localparam int INT_W   = 5;

  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [LIN_W-1:0]  LIN_RST  = 6'h00;
  localparam logic [15:0]       BAUD_RST = 16'h06C8;
  localparam logic [1:0]        HTRANS_NONSEQ = 2'h2;

  localparam logic [4:0] BRK_BASE_BITS = 5'h0D;
  localparam logic [5:0] RX_TO_BITS    = 6'h20;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;

  typedef enum logic [1:0] {MODE_UART, MODE_LIN, MODE_IRDA, MODE_SC}
    ulis_mode_e;
  typedef enum logic [2:0] {T_IDLE, T_BRK, T_START, T_DATA, T_PAR, T_STOP}
    ulis_txst_e;
  typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP}
    ulis_rxst_e;
endpackage

// ===== design/ulis_sync2.sv
// Purpose: two-flop synchroniser for the receive pin
// Assumes: pin idles high
// Notes: first flop feeds only the second
`timescale 1ns/100ps
module ulis_sync2 (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  input  wire logic din,
  output logic      dout
);
  logic meta_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= 1'b1;
      dout   <= 1'b1;
    end else if (ce) begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule

// ===== design/ulis_top.sv
// Purpose: serial port with LIN break, infrared and smart-card modes
// Assumes: baud divisor of at least 4 cycles per bit
// Notes: one-byte holding register each way, no FIFO
`timescale 1ns/100ps
module ulis_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        serial_rx_line,
  output logic             serial_tx_line,
  output logic             sc_data_line,
  output logic             irq,
  output logic             dma_rx_req,
  output logic             dma_tx_req
);
  import ulis_pkg::*;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic              rx_s;
  logic              wr_r, wr_nxt;
  logic [7:0]        wa_r, wa_nxt;
  logic [31:0]       rd_nxt;
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [LIN_W-1:0]  lin_control_reg_r, lin_control_reg_nxt;
  logic [15:0]       baud_r, baud_nxt;
  logic [INT_W-1:0]  raw_int_status_r, raw_nxt;
  logic [INT_W-1:0]  int_mask_reg_r, mask_nxt;
  logic [7:0]        tx_hold_r, tx_hold_nxt, rx_data_r, rx_data_nxt;
  logic              tx_full_r, tx_full_nxt, rx_full_r, rx_full_nxt;
  logic [INT_W-1:0]  int_set;
  logic              en, par_en, rd_pop;
  ulis_mode_e        mode;
  logic [1:0]        break_length_field;

  assign en   = ctrl_r[CTRL_EN];
  assign mode = ulis_mode_e'(ctrl_r[CTRL_MODE +: 2]);
  assign par_en = ctrl_r[CTRL_PAR_EN];
  assign break_length_field = lin_control_reg_r[LIN_BREAK_LENGTH_FIELD +: 2];

  ulis_sync2 u_rx_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .din     (serial_rx_line),
    .dout    (rx_s)
  );

  // transmit engine signals
  ulis_txst_e  tst_r, tst_nxt;
  logic [15:0] tcnt_r, tcnt_nxt;
  logic [4:0]  tbit_r, tbit_nxt;
  logic [7:0]  tsh_r, tsh_nxt;
  logic        tpar_r, tpar_nxt, line_r, line_nxt;
  logic        tx_nxt, scd_nxt, tx_take, tx_done, brk_start, brk_done;
  logic        bit_end;
  logic [17:0] ir_w;
  logic [31:0] brk_cyc_r;

  // receive engine signals
  ulis_rxst_e  rst_r, rst_nxt;
  logic [15:0] rcnt_r, rcnt_nxt;
  logic [2:0]  rbit_r, rbit_nxt;
  logic [7:0]  rsh_r, rsh_nxt;
  logic        rpar_r, rpar_nxt, rto_r, rto_nxt;
  logic [5:0]  ridle_r, ridle_nxt;
  logic        rx_put, pe_evt, to_evt;

  // register group
  always_comb begin
    rd_pop   = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite
               && haddr[7:0] == OFF_DATA;
    wr_nxt   = hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
    wa_nxt   = haddr[7:0];
    rd_nxt   = 32'h0000_0000;
    if (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite) begin
      case (haddr[7:0])
        OFF_DATA:   rd_nxt = {24'h000000, rx_data_r};
        OFF_CTRL:   rd_nxt = {26'h0000000, ctrl_r};
        OFF_LINCTL: rd_nxt = {26'h0000000, lin_control_reg_r};
        OFF_BAUD:   rd_nxt = {16'h0000, baud_r};
        OFF_RIS:    rd_nxt = {27'h0000000, raw_int_status_r};
        OFF_IM:     rd_nxt = {27'h0000000, int_mask_reg_r};
        OFF_MIS:    rd_nxt = {27'h0000000,
                              raw_int_status_r & int_mask_reg_r}; // RL8
        OFF_STAT:   rd_nxt = {29'h00000000, tst_r != T_IDLE,
                              tx_full_r, rx_full_r};
        default:    rd_nxt = 32'h0000_0000;
      endcase
    end
    ctrl_nxt = ctrl_r;
    lin_control_reg_nxt = lin_control_reg_r;
    baud_nxt = baud_r;
    mask_nxt = int_mask_reg_r;
    tx_hold_nxt = tx_hold_r;
    tx_full_nxt = tx_full_r && !tx_take;
    rx_full_nxt = rx_full_r && !rd_pop;
    rx_data_nxt = rx_data_r;
    // raw flags set with no regard to the mask
    int_set = '0;
    int_set[INT_RX]  = rx_put;
    int_set[INT_TX]  = tx_done;
    int_set[INT_RT]  = to_evt; // RL2
    int_set[INT_PE]  = pe_evt; // RL4
    int_set[INT_BRK] = brk_done;
    raw_nxt = raw_int_status_r;
    if (brk_start) begin
      lin_control_reg_nxt[LIN_BRK_GO] = 1'b0;
    end
    if (wr_r) begin
      case (wa_r)
        OFF_DATA: begin
          tx_hold_nxt = hwdata[7:0];
          tx_full_nxt = 1'b1;
        end
        OFF_CTRL:   ctrl_nxt = hwdata[CTRL_W-1:0];
        OFF_LINCTL: lin_control_reg_nxt = hwdata[LIN_W-1:0];
        OFF_BAUD:   baud_nxt = hwdata[15:0];
        OFF_RIS:    raw_nxt = raw_int_status_r & ~hwdata[INT_W-1:0];
        OFF_IM:     mask_nxt = hwdata[INT_W-1:0];
        default:    ;
      endcase
    end
    // a set in the clearing cycle wins
    raw_nxt = raw_nxt | int_set;
    if (rx_put) begin
      rx_data_nxt = rsh_r;
      rx_full_nxt = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 1'b0;
      wa_r <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ctrl_r <= CTRL_RST;
      lin_control_reg_r <= LIN_RST;
      baud_r <= BAUD_RST;
      raw_int_status_r <= '0;
      int_mask_reg_r <= '0;
      tx_hold_r <= 8'h00;
      tx_full_r <= 1'b0;
      rx_data_r <= 8'h00;
      rx_full_r <= 1'b0;
      irq <= 1'b0;
      dma_rx_req <= 1'b0;
      dma_tx_req <= 1'b0;
    end else if (ce) begin
      wr_r <= wr_nxt;
      wa_r <= wa_nxt;
      hrdata <= rd_nxt;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ctrl_r <= ctrl_nxt;
      lin_control_reg_r <= lin_control_reg_nxt;
      baud_r <= baud_nxt;
      raw_int_status_r <= raw_nxt;
      int_mask_reg_r <= mask_nxt;
      tx_hold_r <= tx_hold_nxt;
      tx_full_r <= tx_full_nxt;
      rx_data_r <= rx_data_nxt;
      rx_full_r <= rx_full_nxt;
      irq <= |(raw_int_status_r & int_mask_reg_r); // RL8
      // level requests, usable as single requests in every mode
      dma_rx_req <= ctrl_r[CTRL_DMA_RX] && rx_full_r; // RL6
      dma_tx_req <= ctrl_r[CTRL_DMA_TX] && !tx_full_r; // RL6
    end
  end

  // transmit engine; bit timer runs freely so the card clock is steady
  always_comb begin
    bit_end = tcnt_r == baud_r - 16'h0001;
    tcnt_nxt = (bit_end || !en) ? 16'h0000 : tcnt_r + 16'h0001;
    ir_w = 18'({2'b00, baud_r} * 18'd3) >> 4;
    tst_nxt = tst_r;
    tbit_nxt = tbit_r;
    tsh_nxt = tsh_r;
    tpar_nxt = tpar_r;
    line_nxt = line_r;
    tx_take = 1'b0;
    tx_done = 1'b0;
    brk_start = 1'b0;
    brk_done = 1'b0;
    case (tst_r)
      T_IDLE: begin
        line_nxt = 1'b1;
        if (bit_end && en && mode == MODE_LIN
            && lin_control_reg_r[LIN_BRK_GO]) begin
          tst_nxt = T_BRK;
          tbit_nxt = 5'h00;
          brk_start = 1'b1;
          line_nxt = 1'b0;
        end else if (bit_end && en && tx_full_r) begin
          tst_nxt = T_START;
          tsh_nxt = tx_hold_r;
          tpar_nxt = 1'b0;
          tx_take = 1'b1;
          line_nxt = 1'b0;
        end
      end
      T_BRK: if (bit_end) begin
        // nominal length, not one bit short
        if (tbit_r == BRK_BASE_BITS + {3'b000, break_length_field}
                      - 5'h01) begin // RL1
          tst_nxt = T_STOP;
          line_nxt = 1'b1;
          brk_done = 1'b1;
        end else begin
          tbit_nxt = tbit_r + 5'h01;
        end
      end
      T_START: if (bit_end) begin
        tst_nxt = T_DATA;
        tbit_nxt = 5'h00;
        line_nxt = tsh_r[0];
      end
      T_DATA: if (bit_end) begin
        tpar_nxt = tpar_r ^ tsh_r[0];
        tsh_nxt = {1'b0, tsh_r[7:1]};
        if (tbit_r[2:0] == LAST_DATA_BIT) begin
          tst_nxt = par_en ? T_PAR : T_STOP;
          line_nxt = par_en ? (tpar_r ^ tsh_r[0]) : 1'b1;
        end else begin
          tbit_nxt = tbit_r + 5'h01;
          line_nxt = tsh_r[1];
        end
      end
      T_PAR: if (bit_end) begin
        tst_nxt = T_STOP;
        line_nxt = 1'b1;
      end
      T_STOP: if (bit_end) begin
        tst_nxt = T_IDLE;
        tx_done = 1'b1;
      end
      default: tst_nxt = T_IDLE;
    endcase
    case (mode)
      MODE_SC:   tx_nxt = en && tcnt_r < {1'b0, baud_r[15:1]}; // RL3
      MODE_IRDA: tx_nxt = !line_r && tst_r != T_IDLE
                          && {2'b00, tcnt_r} < ir_w;
      default:   tx_nxt = line_r;
    endcase
    scd_nxt = (mode == MODE_SC) ? line_r : 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tst_r <= T_IDLE;
      tcnt_r <= 16'h0000;
      tbit_r <= 5'h00;
      tsh_r <= 8'h00;
      tpar_r <= 1'b0;
      line_r <= 1'b1;
      serial_tx_line <= 1'b1;
      sc_data_line <= 1'b1;
      brk_cyc_r <= 32'h0000_0000;
    end else if (ce) begin
      tst_r <= tst_nxt;
      tcnt_r <= tcnt_nxt;
      tbit_r <= tbit_nxt;
      tsh_r <= tsh_nxt;
      tpar_r <= tpar_nxt;
      line_r <= line_nxt;
      serial_tx_line <= tx_nxt;
      sc_data_line <= scd_nxt;
      brk_cyc_r <= (tst_r == T_BRK) ? brk_cyc_r + 32'h1 : 32'h0;
    end
  end

  // receive engine; in infrared mode an idle high line keeps it quiet
  always_comb begin
    rst_nxt = rst_r;
    rcnt_nxt = rcnt_r + 16'h0001;
    rbit_nxt = rbit_r;
    rsh_nxt = rsh_r;
    rpar_nxt = rpar_r;
    ridle_nxt = ridle_r;
    rto_nxt = rto_r && rx_full_r;
    rx_put = 1'b0;
    pe_evt = 1'b0;
    to_evt = 1'b0;
    case (rst_r)
      R_IDLE: begin
        if (!en) begin
          rcnt_nxt = 16'h0000;
          ridle_nxt = 6'h00;
        end else if (!rx_s) begin // RL5
          rst_nxt = R_START;
          rcnt_nxt = 16'h0000;
          ridle_nxt = 6'h00;
          rto_nxt = 1'b0;
        end else if (rcnt_r == baud_r - 16'h0001) begin
          rcnt_nxt = 16'h0000;
          if (ridle_r != RX_TO_BITS) begin
            ridle_nxt = ridle_r + 6'h01;
          end else if (rx_full_r && !rto_r) begin
            to_evt = 1'b1;
            rto_nxt = 1'b1;
          end
        end
      end
      R_START: if (rcnt_r == {1'b0, baud_r[15:1]}) begin
        rcnt_nxt = 16'h0000;
        rbit_nxt = 3'h0;
        rpar_nxt = 1'b0;
        rst_nxt = rx_s ? R_IDLE : R_DATA;
      end
      R_DATA: if (rcnt_r == baud_r - 16'h0001) begin
        rcnt_nxt = 16'h0000;
        rsh_nxt = {rx_s, rsh_r[7:1]};
        rpar_nxt = rpar_r ^ rx_s;
        rbit_nxt = rbit_r + 3'h1;
        if (rbit_r == LAST_DATA_BIT) begin
          rst_nxt = par_en ? R_PAR : R_STOP;
        end
      end
      R_PAR: if (rcnt_r == baud_r - 16'h0001) begin
        rcnt_nxt = 16'h0000;
        rpar_nxt = rpar_r ^ rx_s;
        rst_nxt = R_STOP;
      end
      R_STOP: if (rcnt_r == baud_r - 16'h0001) begin
        rcnt_nxt = 16'h0000;
        rst_nxt = R_IDLE;
        rx_put = 1'b1;
        pe_evt = par_en && rpar_r; // RL4
      end
      default: rst_nxt = R_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_r <= R_IDLE;
      rcnt_r <= 16'h0000;
      rbit_r <= 3'h0;
      rsh_r <= 8'h00;
      rpar_r <= 1'b0;
      ridle_r <= 6'h00;
      rto_r <= 1'b0;
    end else if (ce) begin
      rst_r <= rst_nxt;
      rcnt_r <= rcnt_nxt;
      rbit_r <= rbit_nxt;
      rsh_r <= rsh_nxt;
      rpar_r <= rpar_nxt;
      ridle_r <= ridle_nxt;
      rto_r <= rto_nxt;
    end
  end

  sequence s_mis_addr;
    hsel && hready && htrans == HTRANS_NONSEQ && !hwrite
      && haddr[7:0] == OFF_MIS && ce;
  endsequence
  sequence s_brk_exit;
    ce && tst_r == T_BRK && tst_nxt != T_BRK;
  endsequence

  property p_break_len;
    s_brk_exit |-> brk_cyc_r + 32'h1 ==
      32'(BRK_BASE_BITS + break_length_field) * 32'(baud_r);
  endproperty
  a_break_len: assert property (p_break_len) // RL1
    else $error("break length wrong");

  property p_to_raw;
    (ce && to_evt && !int_mask_reg_r[INT_RT]) |=> raw_int_status_r[INT_RT];
  endproperty
  a_to_raw: assert property (p_to_raw) // RL2
    else $error("timeout flag not set while masked");

  property p_sc_clock;
    (ce && en && mode == MODE_SC && tcnt_r == 16'h0000) |=>
      serial_tx_line;
  endproperty
  a_sc_clock: assert property (p_sc_clock) // RL3
    else $error("card clock missing");

  property p_no_phantom;
    $rose(irq) |-> $past(|(raw_int_status_r & int_mask_reg_r));
  endproperty
  a_no_phantom: assert property (p_no_phantom) // RL4
    else $error("interrupt without flag");

  property p_dma_single;
    (ce && (mode == MODE_LIN || mode == MODE_IRDA) && rx_full_r
     && ctrl_r[CTRL_DMA_RX]) |=> dma_rx_req;
  endproperty
  a_dma_single: assert property (p_dma_single) // RL6
    else $error("no DMA request");

  property p_mis_read;
    s_mis_addr |=> hrdata[INT_W-1:0] ==
      $past(raw_int_status_r & int_mask_reg_r);
  endproperty
  a_mis_read: assert property (p_mis_read) // RL8
    else $error("masked status mismatch");
endmodule

// ===== verif/ulis_node.sv
// Purpose: remote serial node facing the port
// Assumes: BAUD cycles per bit, lines idle high
// Notes: decoder ignores parity; break shows as a low run
`timescale 1ns/100ps
module ulis_node #(
  parameter int BAUD = 8
) (
  input  wire logic hclk,
  input  wire logic tx_line,
  output logic      rx_line
);
  logic [15:0] lo_cnt;
  logic [15:0] low_len;
  logic [7:0]  got_byte;
  initial begin
    rx_line  = 1'b1;
    lo_cnt   = 16'h0000;
    low_len  = 16'h0000;
    got_byte = 8'h00;
  end
  // low-run meter, latched on the rising edge of the line
  always @(posedge hclk) begin
    if (tx_line === 1'b0) begin
      lo_cnt <= lo_cnt + 16'h0001;
    end else begin
      if (lo_cnt != 16'h0000) begin
        low_len <= lo_cnt;
      end
      lo_cnt <= 16'h0000;
    end
  end
  // mid-bit sampling, lsb first
  initial begin
    forever begin
      @(negedge tx_line);
      repeat (BAUD / 2) @(posedge hclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BAUD) @(posedge hclk);
        got_byte[i] = tx_line;
      end
    end
  end
  // line ends high after the stop bit
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge hclk);
      rx_line <= f[i];
      repeat (BAUD - 1) @(posedge hclk);
    end
  endtask
endmodule

// ===== verif/ulis_top_tb.sv
// Purpose: self-checking bench of the serial port
// Assumes: BAUD set to 8 cycles per bit
// Notes: bus waits are bounded by the cycle ceiling only
`timescale 1ns/100ps
module ulis_top_tb;
  import ulis_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        rx_line;
  logic        tx_line;
  logic        irq;
  logic        dma_rx_req;
  logic        dma_tx_req;
  logic        sc_line;
  int          sc_low;
  int          err_count;
  int          comparisons;

  ulis_top dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .serial_rx_line(rx_line),
    .serial_tx_line(tx_line), .sc_data_line(sc_line), .irq(irq),
    .dma_rx_req(dma_rx_req), .dma_tx_req(dma_tx_req));
  ulis_node #(.BAUD(8)) node (.hclk(hclk), .tx_line(tx_line),
    .rx_line(rx_line));
  // low cycles of the card data line, for the frame check
  always @(posedge hclk) begin
    if (sc_line === 1'b0) begin
      sc_low <= sc_low + 1;
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    bus(1'b0, a, 32'h00000000, v);
    chk(nm, e, v & m);
  endtask
  // bounded poll; the caller's compare judges the outcome
  task automatic wait_bit(input logic [7:0] a, input logic [31:0] m);
    logic [31:0] v;
    for (int i = 0; i < 400; i++) begin
      bus(1'b0, a, 32'h00000000, v);
      if ((v & m) !== 32'h00000000) break;
    end
  endtask

  task automatic t_reset();
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("tx idle", 32'h1, {31'h0, tx_line});
    chk("sc idle", 32'h1, {31'h0, sc_line});
    chk("irq", 32'h0, {31'h0, irq});
    rchk("baud", OFF_BAUD, 32'hFFFFFFFF, {16'h0000, BAUD_RST});
    rchk("ctrl", OFF_CTRL, 32'hFFFFFFFF, 32'h0);
    rchk("ris", OFF_RIS, 32'hFFFFFFFF, 32'h0);
    rchk("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0);
    $display("done: reset");
  endtask
  task automatic t_break();
    wr(OFF_BAUD, 32'h8);
    wr(OFF_CTRL, 32'h3);
    for (int f = 0; f < 4; f++) begin
      wr(OFF_LINCTL, (f << LIN_BREAK_LENGTH_FIELD) | 1);
      wait_bit(OFF_RIS, 32'h10);
      // meter latches one edge after the line rises, two after the flag sets
      repeat (4) @(posedge hclk);
      chk("break low", (13 + f) * 8, {16'h0, node.low_len});
      wr(OFF_RIS, 32'h10);
      rchk("break flag", OFF_RIS, 32'h10, 32'h0);
    end
    $display("done: break");
  endtask
  task automatic t_tx();
    // break frames leave a tx-done flag behind
    wr(OFF_RIS, 32'h1F);
    wr(OFF_CTRL, 32'h23);
    repeat (2) @(posedge hclk);
    chk("dma tx", 32'h1, {31'h0, dma_tx_req});
    wr(OFF_DATA, 32'hA3);
    wait_bit(OFF_RIS, 32'h2);
    chk("tx byte", 32'hA3, {24'h0, node.got_byte});
    wr(OFF_RIS, 32'h2);
    $display("done: tx");
  endtask
  // receive by polling the raw level flag and reading over the bus; dma request level checked alongside
  task automatic t_rx();
    wr(OFF_IM, 32'h0);
    wr(OFF_RIS, 32'h1F);
    wr(OFF_CTRL, 32'h13);
    node.send(8'h3C);
    wait_bit(OFF_RIS, 32'h1);
    chk("irq masked", 32'h0, {31'h0, irq});
    chk("dma rx", 32'h1, {31'h0, dma_rx_req});
    wr(OFF_IM, 32'h1);
    rchk("mis", OFF_MIS, 32'h1F, 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    wait_bit(OFF_RIS, 32'h4);
    rchk("timeout raw", OFF_RIS, 32'h4, 32'h4);
    rchk("mis", OFF_MIS, 32'h1F, 32'h1);
    rchk("rx byte", OFF_DATA, 32'hFF, 32'h3C);
    rchk("rx full", OFF_STAT, 32'h1, 32'h0);
    chk("dma rx", 32'h0, {31'h0, dma_rx_req});
    wr(OFF_IM, 32'h0);
    wr(OFF_RIS, 32'h1F);
    $display("done: rx");
  endtask
  task automatic t_sc();
    int n;
    n = 0;
    wr(OFF_CTRL, 32'hF);
    // skip the cycle that still shows the old mode
    repeat (2) @(posedge hclk);
    repeat (32) @(posedge hclk) n += (tx_line === 1'b1);
    chk("bit clock high", 32'd16, n);
    n = sc_low;
    wr(OFF_DATA, 32'h5A);
    wait_bit(OFF_RIS, 32'h2);
    // start, four zero data bits and even parity are low
    chk("sc data low", 32'd48, sc_low - n);
    rchk("parity raw", OFF_RIS, 32'h8, 32'h0);
    wr(OFF_IM, 32'h8);
    rchk("parity mis", OFF_MIS, 32'h8, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    wr(OFF_IM, 32'h0);
    wr(OFF_CTRL, 32'h0);
    $display("done: smart card");
  endtask

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // hang guard, far above the run's length
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    end_of_test();
  end
  initial begin
    err_count   = 0;
    comparisons = 0;
    sc_low      = 0;
    hresetn     = 1'b0;
    hsel        = 1'b0;
    haddr       = 32'h00000000;
    htrans      = 2'h0;
    hwrite      = 1'b0;
    hwdata      = 32'h00000000;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_break();
    t_tx();
    t_rx();
    t_sc();
    end_of_test();
  end
endmodule
